// *** rtl/wdg_params.svh ***
/*
 * Constants for the watchdog block: register offsets, field positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the watchdog package and modules.
 */
`ifndef WDG_PARAMS_SVH
`define WDG_PARAMS_SVH

// ==========================================================
// register map (byte addresses on the 32-bit bus)
`define WDG_ADDR_W 4
`define WDG_OFS_CONTROL 4'h0
`define WDG_OFS_CAUSE 4'h4
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

// ==========================================================
// watchdog_control fields
`define WDG_PRESC_LSB 0
`define WDG_PRESC_MSB 2
`define WDG_EN_BIT 3
`define WDG_CE_BIT 4
`define WDG_PRESC_RST 3'h0

// ==========================================================
// reset_cause_register fields
`define WDG_FLAG_BIT 3

// ==========================================================
// timing
`define WDG_SYS_CLK_HZ 50000000
`define WDG_OSC_HZ 1000000
`define WDG_TICK_DIV (`WDG_SYS_CLK_HZ / `WDG_OSC_HZ)
`define WDG_DIV_W 6
`define WDG_CE_CYCLES 4
`define WDG_CE_W 3
`define WDG_BASE_CYCLES 16384
`define WDG_CNT_W 22

`endif

// *** rtl/wdg_pkg.sv ***
/*
 * Types shared by the watchdog modules.
 * Assumes wdg_params.svh is on the include path.
 */
`include "wdg_params.svh"

package wdg_pkg;
	// safety level chosen by the two fuses
	typedef enum logic [1:0] {
		WDG_LVL0,
		WDG_LVL1,
		WDG_LVL2
	} wdg_level_e;

	typedef logic [`WDG_CNT_W-1:0] wdg_cnt_t;
endpackage

// *** rtl/wdg_counter.sv ***
/*
 * Watchdog timeout counter, advanced by the 1 MHz oscillator enable.
 * Assumes tick_i is a one-cycle pulse on clk_sys_i and that clear_i and
 * enable_i come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdg_params.svh"

module wdg_counter
	import wdg_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = `WDG_BASE_CYCLES
)(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic clear_i,
	input wire logic enable_i,
	input wire logic [2:0] presc_i,
	output logic timeout_o
);
	// ==========================================================
	// period lookup
	// last count of the window: base doubled per prescale code, minus one
	function automatic wdg_cnt_t last_count(input logic [2:0] sel);
		last_count = wdg_cnt_t'((BASE_CYCLES << sel) - 1);
	endfunction

	wdg_cnt_t count; // oscillator cycles since last clear
	wdg_cnt_t next_count;
	logic next_timeout;

	// ==========================================================
	// next count and expiry
	always_comb
	begin
		next_count = count;
		next_timeout = 1'b0;
		// disabled or cleared: restart the window [RQ2] [RQ3]
		if (clear_i || !enable_i)
		begin
			next_count = '0;
		end
		else if (tick_i)
		begin
			// expiry: one-cycle pulse, counter restarts [RQ4]
			if (count >= last_count(presc_i))
			begin
				next_count = '0;
				next_timeout = 1'b1;
			end
			else
			begin
				next_count = count + wdg_cnt_t'(1);
			end
		end
	end

	// registers; any chip reset empties the counter [RQ3]
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			count <= '0;
			timeout_o <= 1'b0;
		end
		else
		begin
			count <= next_count;
			timeout_o <= next_timeout;
		end
	end
endmodule

`default_nettype wire

// *** rtl/wdg_top.sv ***
/*
 * Watchdog timer with fuse-selected safety levels, AXI4-Lite registers.
 * Assumes: one 50 MHz clock, synchronous reset held at least 4 edges,
 * fuses static, clear instruction and power-on flag on the same clock.
 */
// How it works
// [RQ1] counter runs on own 1 MHz oscillator
// [RQ2] clear instruction zeroes the counter
// [RQ3] disable or chip reset also zeroes counter
// [RQ4] period elapsed without clear raises chip reset
// [RQ5] three prescale bits pick 16384 doubling cycles
// [RQ6] fuses pick safety level and initial enable
// [RQ7] writing enable one always enables, untimed
// [RQ8] top three control bits read zero
// [RQ9] change enable self-clears four cycles later
// [RQ10] enable zero only takes while change enable
// [RQ11] software opens sequence, disables within four
// [RQ12] level two ignores every disable attempt
// [RQ13] levels one, two: prescale needs change enable
// [RQ14] level zero: prescale changes any time
// [RQ15] second write within four, change enable zero
// [RQ16] level two: always enabled, reads one
// [RQ17] level two: second write sets prescale only
// [RQ18] timeout gives one-cycle internal reset pulse
// [RQ19] reset flag set by timeout, cleared by software
// [RQ20] oscillator-domain crossings handled safely
`timescale 1ns/1ps
`default_nettype none
`include "wdg_params.svh"

module wdg_top
	import wdg_pkg::*;
#(
	parameter int unsigned BASE_CYCLES = `WDG_BASE_CYCLES
)(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic por_i,
	input wire logic wdr_i,
	input wire logic always_on_fuse_i,
	input wire logic compatibility_fuse_i,
	input wire logic [`WDG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`WDG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wdt_reset_o,
	output logic wdt_enabled_o
);
	// ==========================================================
	// fuse sampling
	// fuses are pins: three flops, value used once stages 2 and 3 agree
	logic [2:0] aon_sync;
	logic [2:0] cmp_sync;
	wdg_level_e level; // safety level, settled during reset
	wdg_level_e next_level;

	// fuse decode; always-on wins regardless of the compatibility fuse
	function automatic wdg_level_e fuse_level(input logic aon, input logic cmp);
		if (aon)
			fuse_level = WDG_LVL2;
		else if (cmp)
			fuse_level = WDG_LVL0;
		else
			fuse_level = WDG_LVL1;
	endfunction

	// level reloads only inside reset so it cannot move under software
	always_comb
	begin
		next_level = level;
		if (sys_rst_i && (aon_sync[1] == aon_sync[2]) && (cmp_sync[1] == cmp_sync[2]))
		begin
			next_level = fuse_level(aon_sync[2], cmp_sync[2]); // [RQ6]
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		aon_sync <= {aon_sync[1:0], always_on_fuse_i};
		cmp_sync <= {cmp_sync[1:0], compatibility_fuse_i};
		level <= next_level;
	end

	// ==========================================================
	// oscillator enable
	// the 1 MHz oscillator is modelled as a one-cycle enable from a divider,
	// so every crossing is same-clock and needs no synchroniser [RQ20]
	logic [`WDG_DIV_W-1:0] div_cnt;
	logic [`WDG_DIV_W-1:0] next_div_cnt;
	logic osc_tick;
	logic next_osc_tick;

	always_comb
	begin
		next_div_cnt = div_cnt + `WDG_DIV_W'(1);
		next_osc_tick = 1'b0;
		if (div_cnt == `WDG_DIV_W'(`WDG_TICK_DIV - 1))
		begin
			next_div_cnt = '0;
			next_osc_tick = 1'b1; // [RQ1]
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			div_cnt <= '0;
			osc_tick <= 1'b0;
		end
		else
		begin
			div_cnt <= next_div_cnt;
			osc_tick <= next_osc_tick;
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	logic aw_held; // address accepted, waiting for data or response
	logic w_held;
	logic [`WDG_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0; // byte lane 0 enabled
	logic next_aw_held;
	logic next_w_held;
	logic [`WDG_ADDR_W-1:0] next_aw_addr;
	logic [7:0] next_w_byte;
	logic next_w_lane0;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic wr_fire; // one write is applied this cycle
	logic wr_ctrl;
	logic wr_cause;

	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_byte = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		wr_fire = 1'b0;
		// take each channel independently, in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata[7:0];
			next_w_lane0 = s_axi_wstrb[0];
		end
		// both halves in hand and no response pending: apply and answer
		if (aw_held && w_held && !s_axi_bvalid)
		begin
			wr_fire = 1'b1;
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (aw_addr == `WDG_OFS_CONTROL || aw_addr == `WDG_OFS_CAUSE)
				? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			next_bvalid = 1'b0;
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
		wr_ctrl = wr_fire && w_lane0 && (aw_addr == `WDG_OFS_CONTROL);
		wr_cause = wr_fire && w_lane0 && (aw_addr == `WDG_OFS_CAUSE);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_byte <= '0;
			w_lane0 <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WDG_RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_byte <= next_w_byte;
			w_lane0 <= next_w_lane0;
			s_axi_awready <= next_awready;
			s_axi_wready <= next_wready;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
		end
	end

	// ==========================================================
	// watchdog_control state
	logic en; // watchdog_enable_bit
	logic ce; // change_enable_bit
	logic [`WDG_CE_W-1:0] ce_cnt; // cycles left while change enable is open
	logic [2:0] presc; // prescale_sel_bit2..0
	logic next_en;
	logic next_ce;
	logic [`WDG_CE_W-1:0] next_ce_cnt;
	logic [2:0] next_presc;
	logic wr_en_bit;
	logic wr_ce_bit;

	always_comb
	begin
		next_en = en;
		next_ce = ce;
		next_ce_cnt = ce_cnt;
		next_presc = presc;
		wr_en_bit = w_byte[`WDG_EN_BIT];
		wr_ce_bit = w_byte[`WDG_CE_BIT];
		// change-enable window runs down, then hardware clears it [RQ9]
		if (ce)
		begin
			next_ce_cnt = ce_cnt - `WDG_CE_W'(1);
			if (ce_cnt == `WDG_CE_W'(1))
				next_ce = 1'b0;
		end
		if (wr_ctrl)
		begin
			// enabling needs no sequence in any level [RQ7] [RQ10]
			if (wr_en_bit)
				next_en = 1'b1;
			// disable only inside an open window, never at level 2 [RQ10] [RQ11] [RQ12]
			else if (ce && level != WDG_LVL2)
				next_en = 1'b0;
			// prescale: free at level 0, else needs the open window [RQ13] [RQ14] [RQ17]
			if (level == WDG_LVL0 || ce)
				next_presc = w_byte[`WDG_PRESC_MSB:`WDG_PRESC_LSB]; // [RQ5]
			// opening write: change enable and enable in one write [RQ11] [RQ15] [RQ17]
			if (wr_ce_bit && wr_en_bit)
			begin
				next_ce = 1'b1;
				next_ce_cnt = `WDG_CE_W'(`WDG_CE_CYCLES);
			end
		end
		// level 2 keeps the watchdog running whatever was written [RQ16]
		if (level == WDG_LVL2)
			next_en = 1'b1;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			en <= (next_level == WDG_LVL2); // initial state from the fuses [RQ6]
			ce <= 1'b0;
			ce_cnt <= '0;
			presc <= `WDG_PRESC_RST;
		end
		else
		begin
			en <= next_en;
			ce <= next_ce;
			ce_cnt <= next_ce_cnt;
			presc <= next_presc;
		end
	end

	// ==========================================================
	// timeout counter and internal reset pulse
	logic timeout;

	wdg_counter #(
		.BASE_CYCLES(BASE_CYCLES)
	) u_counter (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.tick_i(osc_tick),
		.clear_i(wdr_i), // [RQ2]
		.enable_i(en), // [RQ3]
		.presc_i(presc),
		.timeout_o(timeout)
	);

	// reset-cause flag: hardware set wins over a software clear
	logic cause_flag; // watchdog_reset_flag
	logic next_cause_flag;

	always_comb
	begin
		next_cause_flag = cause_flag;
		if (wr_cause && !w_byte[`WDG_FLAG_BIT])
			next_cause_flag = 1'b0; // [RQ19]
		if (timeout)
			next_cause_flag = 1'b1; // [RQ19]
	end

	// the flag survives the chip reset it reports; only power-on or a software write of zero clears it
	always_ff @(posedge clk_sys_i)
	begin
		if (por_i)
			cause_flag <= 1'b0; // [RQ19]
		else
			cause_flag <= next_cause_flag;
	end

	// one-cycle reset request; the delay counter outside starts on its fall
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			wdt_reset_o <= 1'b0;
			wdt_enabled_o <= 1'b0;
		end
		else
		begin
			wdt_reset_o <= timeout; // [RQ4] [RQ18]
			wdt_enabled_o <= next_en;
		end
	end

	// ==========================================================
	// AXI4-Lite read path
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	always_comb
	begin
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp = `WDG_RESP_OKAY;
			next_rdata = '0; // reserved bits 7..5 and upper bits read zero [RQ8]
			if (s_axi_araddr == `WDG_OFS_CONTROL)
			begin
				next_rdata[`WDG_CE_BIT] = ce;
				next_rdata[`WDG_EN_BIT] = en || (level == WDG_LVL2); // [RQ16]
				next_rdata[`WDG_PRESC_MSB:`WDG_PRESC_LSB] = presc;
			end
			else if (s_axi_araddr == `WDG_OFS_CAUSE)
				next_rdata[`WDG_FLAG_BIT] = cause_flag;
			else
				next_rresp = `WDG_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
			next_rvalid = 1'b0;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `WDG_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= next_arready;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end
	end
endmodule

`default_nettype wire

// *** sim/wdg_props.sv ***
/* wdg_props: port checks on wdg_top.
   Assumes a bind from the bench top and one clock. */
`timescale 1ns/1ps
`default_nettype none
module wdg_props
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic wdr_i,
	input wire logic always_on_fuse_i,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic wdt_reset_o,
	input wire logic wdt_enabled_o
);
	// ==========
	// level two as captured while reset is held
	logic lvl2;
	always_ff @(posedge clk_sys_i)
	begin
		if (sys_rst_i)
			lvl2 <= always_on_fuse_i;
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);
	// ==========
	// assertions
	property p_pulse; $rose(wdt_reset_o) |=> !wdt_reset_o; endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_cause; wdt_reset_o |-> $past(wdt_enabled_o, 2); endproperty
	a_cause: assert property (p_cause) else $error("pulse while off");
	property p_clear; wdr_i |-> ##3 (!wdt_reset_o) [*8]; endproperty
	a_clear: assert property (p_clear) else $error("pulse after kick");
	property p_rdata; s_axi_rvalid |-> s_axi_rdata[31:5] == 27'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("reserved bits set");
	property p_lvl2; lvl2 && !$past(sys_rst_i) |-> wdt_enabled_o; endproperty
	a_lvl2: assert property (p_lvl2) else $error("level two off");
	property p_cfg; $fell(sys_rst_i) && !always_on_fuse_i |=> !wdt_enabled_o; endproperty
	a_cfg: assert property (p_cfg) else $error("bad initial state");
	property p_fall; $fell(wdt_enabled_o) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
	a_fall: assert property (p_fall) else $error("off without write");
	property p_rise;
		$rose(wdt_enabled_o) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(sys_rst_i, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("on without write");
endmodule
`default_nettype wire

// *** sim/wdg_cpu.sv ***
/* wdg_cpu: core model, AXI4-Lite master of the control registers.
   Assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
`default_nettype none
`include "wdg_params.svh"
module wdg_cpu
(
	input wire logic clk_sys_i,
	output logic [`WDG_ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [`WDG_ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	// idle bus
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
	end
	// write: random upper bytes and strobes, only lane 0 matters
	// ready and response are sampled at the falling edge, where they are
	// settled for the next rising edge; this keeps clear of the launch race
	task automatic wr(input logic [`WDG_ADDR_W-1:0] a, input logic [7:0] v,
		output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		logic b_ok;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'($urandom), v};
		s_axi_wstrb <= {3'($urandom), 1'b1};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge clk_sys_i);
			aw_ok = s_axi_awvalid && (s_axi_awready === 1'b1);
			w_ok = s_axi_wvalid && (s_axi_wready === 1'b1);
			b_ok = (s_axi_bvalid === 1'b1);
			r = s_axi_bresp;
			@(posedge clk_sys_i);
			if (aw_ok)
				s_axi_awvalid <= 1'b0;
			if (w_ok)
				s_axi_wvalid <= 1'b0;
		end
		while (!b_ok);
	endtask
	// read: bready/rready stay high once raised
	task automatic rd(input logic [`WDG_ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar_ok;
		logic r_ok;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge clk_sys_i);
			ar_ok = s_axi_arvalid && (s_axi_arready === 1'b1);
			r_ok = (s_axi_rvalid === 1'b1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys_i);
			if (ar_ok)
				s_axi_arvalid <= 1'b0;
		end
		while (!r_ok);
	endtask
	// opening write, then the wanted value with change enable low
	task automatic seq(input logic [7:0] v, output logic [1:0] r);
		wr(`WDG_OFS_CONTROL, 8'h18, r);
		wr(`WDG_OFS_CONTROL, v & 8'hef, r);
	endtask
endmodule
`default_nettype wire

// *** sim/wdg_top_tb.sv ***
/* wdg_top_tb: self-checking bench for the watchdog.
   Assumes rtl and the sim models compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "wdg_params.svh"
module wdg_top_tb;
	localparam int unsigned BASE = 4; // short period keeps the run small
	localparam logic [`WDG_ADDR_W-1:0] CTL = `WDG_OFS_CONTROL;
	localparam logic [`WDG_ADDR_W-1:0] CAU = `WDG_OFS_CAUSE;
	logic clk_sys_i = 0, sys_rst_i = 1, por_i = 1, wdr_i = 0;
	logic always_on_fuse_i = 0, compatibility_fuse_i = 0;
	logic [`WDG_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic wdt_reset_o, wdt_enabled_o;
	int err_count = 0, cmp_count = 0, cyc = 0, pulses = 0;
	wdg_top #(.BASE_CYCLES(BASE)) i_dut (.*);
	wdg_cpu i_cpu (.*);
	always #10 clk_sys_i = ~clk_sys_i;
	// pulse count and hang guard
	always @(posedge clk_sys_i)
	begin
		cyc <= cyc + 1;
		if (wdt_reset_o === 1'b1)
			pulses <= pulses + 1;
		if (cyc == 80000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares=%0d errors=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// timeout in clocks, d ticks off the nominal
	function automatic int unsigned lim(input int p, input int d);
		return ((BASE << p) + d) * 50;
	endfunction
	// fuses settle, then five cycles of chip reset
	task automatic boot(input logic ao, input logic cf);
		always_on_fuse_i <= ao;
		compatibility_fuse_i <= cf;
		@(posedge clk_sys_i);
		sys_rst_i <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic kick();
		wdr_i <= 1'b1;
		@(posedge clk_sys_i);
		wdr_i <= 1'b0;
	endtask
	task automatic rchk(input logic [`WDG_ADDR_W-1:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		i_cpu.rd(a, d, r);
		chk(32'(r), 32'h0);
		chk(d, {24'h0, e});
	endtask
	initial
	begin
		logic [1:0] r;
		logic [31:0] d;
		int n;
		void'($urandom(1544));
		boot(1'b0, 1'b0);
		por_i <= 1'b0;
		rchk(CTL, 8'h00);
		rchk(CAU, 8'h00);
		i_cpu.wr(CTL, 8'h0b, r);
		rchk(CTL, 8'h08);
		i_cpu.wr(CTL, 8'h00, r);
		rchk(CTL, 8'h08);
		i_cpu.seq(8'h01, r);
		rchk(CTL, 8'h01);
		i_cpu.wr(CTL, 8'h18, r);
		repeat (6) @(posedge clk_sys_i);
		i_cpu.wr(CTL, 8'he2, r);
		rchk(CTL, 8'h09);
		// random kick spacing, always inside the period
		i_cpu.seq(8'h08, r);
		n = pulses;
		repeat (20)
		begin
			kick();
			repeat ($urandom_range(120, 20)) @(posedge clk_sys_i);
		end
		chk(32'(pulses), 32'(n));
		i_cpu.seq(8'h00, r);
		repeat (400) @(posedge clk_sys_i);
		chk(32'(pulses), 32'(n));
		// every prescale code to a timeout, then chip reset
		for (int p = 0; p < 8; p++)
		begin
			i_cpu.seq({5'h01, 3'(p)}, r);
			kick();
			n = 0;
			while (wdt_reset_o !== 1'b1 && n < 30000)
			begin
				@(posedge clk_sys_i);
				n++;
			end
			chk(32'(n >= lim(p, -1) && n <= lim(p, 1) + 5), 32'h1);
			boot(1'b0, 1'b0);
			rchk(CAU, 8'h08);
			rchk(CTL, 8'h00);
			if (p % 2)
			begin
				por_i <= 1'b1;
				@(posedge clk_sys_i);
				por_i <= 1'b0;
			end
			else
				i_cpu.wr(CAU, 8'h00, r);
			rchk(CAU, 8'h00);
		end
		boot(1'b0, 1'b1);
		i_cpu.wr(CTL, 8'h03, r);
		rchk(CTL, 8'h03);
		boot(1'b1, 1'b0);
		rchk(CTL, 8'h08);
		chk(32'(wdt_enabled_o), 32'h1);
		i_cpu.seq(8'h02, r);
		rchk(CTL, 8'h0a);
		i_cpu.wr(CTL, 8'h05, r);
		rchk(CTL, 8'h0a);
		// unmapped place
		i_cpu.wr(4'h8, 8'hff, r);
		chk(32'(r), 32'(`WDG_RESP_SLVERR));
		i_cpu.rd(4'h8, d, r);
		chk(32'(r), 32'(`WDG_RESP_SLVERR));
		chk(d, 32'h0);
		tally_and_finish();
	end
endmodule
bind wdg_top wdg_props i_props (.*);
`default_nettype wire
